// file: pabi_top.sv
// asynchronous bus decode, config registers and power states of the psram
`timescale 1ns/1ns
`include "pabi_regs.svh"
module pabi_top
  import pabi_pkg::*;
#(
  parameter int          ADDR_W        = `PABI_ADDR_W,
  parameter logic [7:0]  ACCESS_CYCLES = 8'h02,
  parameter logic [15:0] DEVICE_ID     = 16'h0001 // arbitrary value
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic              address_valid_n,
  input  wire logic              chipSelN,
  input  wire logic              outEnN,
  input  wire logic              writeEnN,
  input  wire logic              low_byte_select_n,
  input  wire logic              high_byte_select_n,
  input  wire logic              config_reg_select,
  input  wire logic [15:0]       dqIn,
  output logic      [15:0]       dqOut,
  output logic      [15:0]       dqOe,
  output logic                   waitOut,
  output logic                   waitOe,
  output logic                   asyncMode,
  output logic                   pageModeEn,
  output logic                   deepPowerDown,
  output logic                   initDone,
  output logic      [15:0]       busConfig,
  output logic      [15:0]       refreshConfig
);

  logic [6:0]        ctrlS;
  logic [ADDR_W-1:0] addrS;
  logic [15:0]       dqS;
  logic              ceNS;
  logic              oeNS;
  logic              weNS;
  logic              lbNS;
  logic              ubNS;
  logic              advNS;
  logic              creS;
  pabi_state_t       state_reg;
  pabi_state_t       state_next;
  logic [`PABI_INIT_CNT_W-1:0] initCnt_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [15:0]       wrData_reg;
  pabi_lanes_t       wrLanes_reg;
  logic              wrCfg_reg;
  logic [15:0]       bus_config_reg;
  logic [15:0]       refresh_config_reg;
  logic              cePrev_reg;
  logic [7:0]        accessCnt_reg;
  logic [15:0]       memRdData;
  pabi_lanes_t       lanesNow;
  logic              readCond;
  logic              writeCond;
  logic              writeEnd;
  logic              ceRise;
  logic              cfgCommit;
  logic              arrayCommit;
  logic              dpdBitAfter;
  logic [1:0]        cfgSel;

  function automatic pabi_lanes_t laneSel(input logic lowN, input logic highN);
    laneSel = {~highN, ~lowN};
  endfunction

  function automatic logic [15:0] laneMask(input pabi_lanes_t l);
    laneMask = {{8{l[1]}}, {8{l[0]}}};
  endfunction

  pabi_sync #(
    .W         (7),
    .RESET_VAL (`PABI_CTRL_IDLE)
  ) u_syncCtrl (
    .mclk  (mclk),
    .reset (reset),
    .din   ({chipSelN, outEnN, writeEnN, low_byte_select_n, high_byte_select_n,
             address_valid_n, config_reg_select}),
    .dout  (ctrlS)
  );

  pabi_sync #(
    .W (ADDR_W)
  ) u_syncAddr (
    .mclk  (mclk),
    .reset (reset),
    .din   (addrIn),
    .dout  (addrS)
  );

  pabi_sync #(
    .W (16)
  ) u_syncData (
    .mclk  (mclk),
    .reset (reset),
    .din   (dqIn),
    .dout  (dqS)
  );

  assign {ceNS, oeNS, weNS, lbNS, ubNS, advNS, creS} = ctrlS;

  assign lanesNow    = laneSel(lbNS, ubNS);
  assign readCond    = ~ceNS & ~oeNS & weNS & (|lanesNow);
  // a low write enable wins over output enable
  assign writeCond   = ~ceNS & ~weNS & (creS | (|lanesNow));
  // previous select resets high, so leaving reset never looks like a select rise
  assign ceRise      = ceNS & ~cePrev_reg;
  // first of select, write enable or, on array writes, a started lane rising ends the write
  assign writeEnd    = ceNS | weNS | (~wrCfg_reg & (|(wrLanes_reg & ~lanesNow)));
  assign cfgSel      = addr_reg[`PABI_CFG_SEL_HI:`PABI_CFG_SEL_LO];
  assign cfgCommit   = (state_reg == ST_WRITE) & writeEnd & wrCfg_reg;
  assign arrayCommit = (state_reg == ST_WRITE) & writeEnd & ~wrCfg_reg;
  // a refresh config write that closes on the select rise must arm power-down
  // in the same cycle, before the register itself has been updated
  assign dpdBitAfter = (cfgCommit && cfgSel == `PABI_SEL_RCR) ?
                       wrData_reg[`PABI_RCR_DPD_BIT] :
                       refresh_config_reg[`PABI_RCR_DPD_BIT];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT: begin
        // bus pins are ignored until self-init has run its full time
        if (initCnt_reg == `PABI_INIT_CNT_W'(`PABI_INIT_CYCLES - 1)) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (ceRise && !dpdBitAfter) begin
          state_next = ST_DPD;
        end else if (writeCond) begin
          state_next = ST_WRITE;
        end else if (readCond) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        if (writeCond) begin
          state_next = ST_WRITE;
        end else if (!readCond) begin
          state_next = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (writeEnd) begin
          state_next = (ceRise && !dpdBitAfter) ? ST_DPD : ST_IDLE;
        end
      end
      ST_DPD: begin
        if (!ceNS) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg  <= ST_INIT;
      cePrev_reg <= 1'b1;
    end else begin
      state_reg  <= state_next;
      cePrev_reg <= ceNS;
    end
  end

  // power-up delay before the bus is honoured
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      initCnt_reg <= '0;
    end else if (state_reg == ST_INIT) begin
      initCnt_reg <= initCnt_reg + `PABI_INIT_CNT_W'(1);
    end
  end

  // address follows the pins while select and valid are low, holds from valid's rising edge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addr_reg <= '0;
    end else if (state_reg != ST_INIT && state_reg != ST_DPD && !ceNS && !advNS) begin
      addr_reg <= addrS;
    end
  end

  // write data follows the bus until the closing edge; lanes are taken on write entry
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wrData_reg  <= '0;
      wrLanes_reg <= '0;
      wrCfg_reg   <= 1'b0;
    end else if (state_next == ST_WRITE) begin
      wrData_reg <= dqS;
      if (state_reg != ST_WRITE) begin
        wrLanes_reg <= lanesNow;
        wrCfg_reg   <= creS;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus_config_reg     <= `PABI_BCR_RESET;
      refresh_config_reg <= `PABI_RCR_RESET;
    end else if (state_reg == ST_INIT) begin
      bus_config_reg     <= `PABI_BCR_RESET;
      refresh_config_reg <= `PABI_RCR_RESET;
    end else if (cfgCommit) begin
      if (cfgSel == `PABI_SEL_BCR) begin
        bus_config_reg <= wrData_reg;
      end else if (cfgSel == `PABI_SEL_RCR) begin
        refresh_config_reg <= wrData_reg;
      end
    end else if (state_reg == ST_DPD && !ceNS) begin
      // leaving power-down re-arms the bit so the next release is plain standby
      refresh_config_reg[`PABI_RCR_DPD_BIT] <= 1'b1;
    end
  end

  pabi_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (`PABI_DATA_W)
  ) u_mem (
    .mclk    (mclk),
    .wrEn    (arrayCommit),
    .wrLanes (wrLanes_reg),
    .wrAddr  (addr_reg),
    .wrData  (wrData_reg),
    .rdAddr  (addr_reg),
    .rdData  (memRdData)
  );

  // access time counted from entry to read or from an address change
  // a held-high address valid freezes the address, so no restart then
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      accessCnt_reg <= '0;
    end else if (state_reg != ST_READ || (!advNS && addrS != addr_reg)) begin
      accessCnt_reg <= '0;
    end else if (accessCnt_reg < ACCESS_CYCLES) begin
      accessCnt_reg <= accessCnt_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dqOut <= '0;
      dqOe  <= '0;
    end else begin
      if (!creS) begin
        dqOut <= memRdData;
      end else if (cfgSel == `PABI_SEL_BCR) begin
        dqOut <= bus_config_reg;
      end else if (cfgSel == `PABI_SEL_RCR) begin
        dqOut <= refresh_config_reg;
      end else if (cfgSel == `PABI_SEL_DEVICE_ID_REG) begin
        dqOut <= DEVICE_ID;
      end else begin
        dqOut <= '0;
      end
      if (state_reg == ST_READ && readCond && accessCnt_reg >= ACCESS_CYCLES) begin
        dqOe <= laneMask(lanesNow);
      end else begin
        dqOe <= '0;
      end
    end
  end

  // wait is asserted at the configured level whenever selected, except during self-init and power-down
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      waitOut <= 1'b0;
      waitOe  <= 1'b0;
    end else begin
      waitOut <= bus_config_reg[`PABI_BCR_WAITPOL_BIT];
      waitOe  <= ~ceNS & (state_reg != ST_INIT) & (state_reg != ST_DPD);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      asyncMode     <= 1'b1;
      pageModeEn    <= 1'b0;
      deepPowerDown <= 1'b0;
      initDone      <= 1'b0;
      busConfig     <= `PABI_BCR_RESET;
      refreshConfig <= `PABI_RCR_RESET;
    end else begin
      asyncMode     <= bus_config_reg[`PABI_BCR_MODE_BIT];
      pageModeEn    <= refresh_config_reg[`PABI_RCR_PAGE_BIT];
      deepPowerDown <= (state_reg == ST_DPD);
      initDone      <= (state_reg != ST_INIT);
      busConfig     <= bus_config_reg;
      refreshConfig <= refresh_config_reg;
    end
  end

endmodule

// file: pabi_regs.svh
// register layout, reset values and timing constants of the psram bus block
// What this block does
// - bus config bit 15 high selects async
// - read: select, output enable, lanes low
// - write: select, write, lanes low or config select; oe ignored
// - write data taken when first strobe rises
// - address latched while address valid low
// - wait driven while selected outside self-init and power-down, controller ignores it
// - standby floats wait, data; isolates inputs
// - deep power-down on select rise after clear, unless the rise ends a read
// - low lane bits 7..0, high 15..8
// - bus config bit 10 sets wait polarity
// - 150 us self-init loads config defaults
// - async mode after power-up until reprogrammed
// - refresh config bit 7 enables page mode
// - array holds 8388608 words of 16 bits
// - config select redirects writes and reads
`ifndef PABI_REGS_SVH
`define PABI_REGS_SVH

`define PABI_DATA_W          16
`define PABI_ADDR_W          23
`define PABI_ARRAY_WORDS     8388608
`define PABI_BCR_MODE_BIT    15
`define PABI_BCR_WAITPOL_BIT 10
`define PABI_RCR_PAGE_BIT    7
`define PABI_RCR_DPD_BIT     4
`define PABI_BCR_RESET       16'h8000
`define PABI_RCR_RESET       16'h0010
`define PABI_CFG_SEL_HI      19
`define PABI_CFG_SEL_LO      18
`define PABI_SEL_RCR         2'h0
`define PABI_SEL_DEVICE_ID_REG        2'h1
`define PABI_SEL_BCR         2'h2
`define PABI_CTRL_IDLE       7'h7e
`define PABI_INIT_TIME_NS    150000
`define PABI_MCLK_PERIOD_NS  100
`define PABI_INIT_CYCLES     ((`PABI_INIT_TIME_NS + `PABI_MCLK_PERIOD_NS - 1) / `PABI_MCLK_PERIOD_NS)
`define PABI_INIT_CNT_W      12

`endif

// file: pabi_pkg.sv
// types shared by the psram bus block
package pabi_pkg;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_DPD
  } pabi_state_t;

  typedef logic [1:0] pabi_lanes_t;

endpackage

// file: pabi_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module pabi_sync #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1_reg;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage1_reg <= RESET_VAL;
      dout       <= RESET_VAL;
    end else begin
      stage1_reg <= din;
      dout       <= stage1_reg;
    end
  end

endmodule

// file: pabi_mem.sv
// word array with byte-lane writes and registered read data
`timescale 1ns/1ns
module pabi_mem
  import pabi_pkg::*;
#(
  parameter int ADDR_W = 23,
  parameter int DATA_W = 16
) (
  input  wire logic              mclk,
  input  wire logic              wrEn,
  input  wire pabi_lanes_t       wrLanes,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData
);

  logic [DATA_W-1:0] words [0:(2**ADDR_W)-1];

  always_ff @(posedge mclk) begin
    if (wrEn && wrLanes[0]) begin
      words[wrAddr][DATA_W/2-1:0] <= wrData[DATA_W/2-1:0];
    end
    if (wrEn && wrLanes[1]) begin
      words[wrAddr][DATA_W-1:DATA_W/2] <= wrData[DATA_W-1:DATA_W/2];
    end
  end

  always_ff @(posedge mclk) begin
    rdData <= words[rdAddr];
  end

endmodule

// file: pabi_top_properties.sv
// concurrent checks on the psram bus block ports
`timescale 1ns/1ns
module pabi_top_properties (
  input logic        mclk,
  input logic        reset,
  input logic        chipSelN,
  input logic        outEnN,
  input logic        writeEnN,
  input logic        low_byte_select_n,
  input logic [15:0] dqOe,
  input logic        waitOut,
  input logic        waitOe,
  input logic        asyncMode,
  input logic        deepPowerDown,
  input logic        initDone,
  input logic [15:0] busConfig,
  input logic [15:0] refreshConfig
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic [11:0] upCnt_reg;
  // edges since reset release, saturating
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      upCnt_reg <= 12'h000;
    end else if (upCnt_reg != 12'hfff) begin
      upCnt_reg <= upCnt_reg + 12'h001;
    end
  end
  sequence readHeld;
    (!chipSelN && !outEnN && writeEnN && !low_byte_select_n && initDone
     && !deepPowerDown)[*8];
  endsequence
  sequence armedRise;
    !refreshConfig[4] && initDone ##1 $rose(chipSelN);
  endsequence
  standby_float_a: assert property (
    chipSelN[*5] |-> !waitOe && dqOe == 16'h0000) else $error("standby outputs driven");
  select_wait_a: assert property (
    (!chipSelN && initDone && !deepPowerDown)[*6] |-> waitOe) else $error("wait not driven");
  wait_polarity_a: assert property (
    $stable(busConfig)[*3] ##0 waitOe |-> waitOut == busConfig[10]) else $error("wait level");
  mode_bit_a: assert property (
    $stable(busConfig)[*3] |-> asyncMode == busConfig[15]) else $error("mode flag");
  init_hold_a: assert property (
    upCnt_reg < 12'h5dc |-> !initDone && busConfig == 16'h8000 && refreshConfig == 16'h0010)
    else $error("early init end");
  init_done_a: assert property (
    upCnt_reg == 12'h5e1 |-> initDone) else $error("init too long");
  dpd_entry_a: assert property (
    armedRise |-> ##[1:8] deepPowerDown) else $error("no power-down");
  dpd_exit_a: assert property (
    deepPowerDown && $fell(chipSelN) |-> ##[1:8] !deepPowerDown) else $error("no wake");
  read_answer_a: assert property (
    readHeld |-> dqOe[7:0] == 8'hff) else $error("read not answered");
  read_float_a: assert property (
    (chipSelN || outEnN || !writeEnN)[*5] |-> dqOe == 16'h0000) else $error("data driven");
endmodule
bind pabi_top pabi_top_properties chk (
  .mclk, .reset, .chipSelN, .outEnN, .writeEnN, .low_byte_select_n, .dqOe, .waitOut,
  .waitOe, .asyncMode, .deepPowerDown, .initDone, .busConfig, .refreshConfig
);

// file: pabi_host_model.sv
// host controller model driving the psram bus pins
`timescale 1ns/1ns
module pabi_host_model
  import pabi_pkg::*;
(
  input  logic        mclk,
  output logic [19:0] addrIn,
  output logic        address_valid_n,
  output logic        chipSelN,
  output logic        outEnN,
  output logic        writeEnN,
  output logic        low_byte_select_n,
  output logic        high_byte_select_n,
  output logic        config_reg_select,
  output logic [15:0] dqIn,
  input  logic [15:0] dqOut,
  input  logic [15:0] dqOe
);
  // select stays high through self-init; no clock pin is driven
  initial begin
    {chipSelN, outEnN, writeEnN, high_byte_select_n, low_byte_select_n} = 5'h1f;
    address_valid_n = 1'b1;
    config_reg_select = 1'b0;
    addrIn = 20'h0_0000;
    dqIn = 16'h0000;
  end
  // wait output is not looked at during async cycles
  task automatic access(input logic wr, input logic cfg, input logic [19:0] a,
                        input logic [15:0] d, input pabi_lanes_t ln,
                        output logic [15:0] q, output logic [15:0] oe);
    q = 16'h0000;
    oe = 16'h0000;
    @(posedge mclk);
    addrIn <= a;
    address_valid_n <= 1'b0;
    config_reg_select <= cfg;
    {high_byte_select_n, low_byte_select_n} <= ~ln;
    outEnN <= 1'b0;
    writeEnN <= !wr;
    dqIn <= d;
    chipSelN <= 1'b0;
    repeat (2) @(posedge mclk);
    address_valid_n <= 1'b1;
    @(posedge mclk);
    addrIn <= ~a;
    if (wr) begin
      repeat (4) @(posedge mclk);
      writeEnN <= 1'b1;
      outEnN <= 1'b1;
      @(posedge mclk);
      dqIn <= ~d;
      repeat (6) @(posedge mclk);
    end else begin
      for (int n = 0; n < 40 && dqOe == 16'h0000; n++) @(posedge mclk);
      q = dqOut;
      oe = dqOe;
      repeat (2) @(posedge mclk);
    end
    {chipSelN, outEnN, writeEnN, high_byte_select_n, low_byte_select_n} <= 5'h1f;
    config_reg_select <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic wake(input int n);
    @(posedge mclk);
    chipSelN <= 1'b0;
    repeat (n) @(posedge mclk);
    chipSelN <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
endmodule

// file: test_pabi_top.sv
// self-checking bench for the psram bus block
`timescale 1ns/1ns
module test_pabi_top;
  import pabi_pkg::*;
  localparam logic [15:0] DEV_ID = 16'h5a5a; // arbitrary value
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [19:0] addrIn;
  logic        address_valid_n, chipSelN, outEnN, writeEnN, config_reg_select;
  logic        low_byte_select_n, high_byte_select_n, waitOut, waitOe;
  logic        asyncMode, pageModeEn, deepPowerDown, initDone;
  logic [15:0] dqIn, dqOut, dqOe, busConfig, refreshConfig;
  int          err_count = 0;
  int          comparisons = 0;
  always #50 mclk = ~mclk;
  pabi_top #(.ADDR_W(20), .DEVICE_ID(DEV_ID)) dut (
    .mclk, .reset, .addrIn, .address_valid_n, .chipSelN, .outEnN, .writeEnN,
    .low_byte_select_n, .high_byte_select_n, .config_reg_select, .dqIn, .dqOut, .dqOe,
    .waitOut, .waitOe, .asyncMode, .pageModeEn, .deepPowerDown, .initDone, .busConfig,
    .refreshConfig
  );
  pabi_host_model host (
    .mclk, .addrIn, .address_valid_n, .chipSelN, .outEnN, .writeEnN, .low_byte_select_n,
    .high_byte_select_n, .config_reg_select, .dqIn, .dqOut, .dqOe
  );
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic flag(input string nm, input logic exp, input logic got);
    check(nm, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic wr(input logic cfg, input logic [19:0] a, input logic [15:0] d,
                    input pabi_lanes_t ln);
    logic [15:0] q, oe;
    host.access(1'b1, cfg, a, d, ln, q, oe);
  endtask
  task automatic rd(input logic cfg, input logic [19:0] a, input pabi_lanes_t ln,
                    input logic [15:0] exp);
    logic [15:0] q, oe, m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    host.access(1'b0, cfg, a, 16'h0000, ln, q, oe);
    check("lane enable", m, oe);
    check("read data", exp & m, q & m);
  endtask
  task automatic t_init;
    check("bus config", 16'h8000, busConfig);
    check("refresh config", 16'h0010, refreshConfig);
    flag("async mode", 1'b1, asyncMode);
    flag("init done", 1'b0, initDone);
    repeat (1505) @(posedge mclk);
    @(negedge mclk);
    flag("init done", 1'b1, initDone);
  endtask
  task automatic t_lanes;
    wr(1'b0, 20'h0_0040, 16'ha5c3, 2'h3);
    wr(1'b0, 20'h0_0040, 16'h3c3c, 2'h2);
    rd(1'b0, 20'h0_0040, 2'h3, 16'h3cc3);
    wr(1'b0, 20'h0_0040, 16'h0055, 2'h1);
    rd(1'b0, 20'h0_0040, 2'h1, 16'h0055);
    rd(1'b0, 20'h0_0040, 2'h2, 16'h3c00);
  endtask
  task automatic t_config;
    logic [15:0] v [2] = '{16'h0400, 16'h8000};
    foreach (v[i]) begin
      wr(1'b1, 20'h8_0000, v[i], 2'h0);
      @(negedge mclk);
      check("bus config", v[i], busConfig);
      flag("async mode", v[i][15], asyncMode);
      flag("wait level", v[i][10], waitOut);
      rd(1'b1, 20'h8_0000, 2'h3, v[i]);
      rd(1'b0, 20'h0_0040, 2'h3, 16'h3c55);
    end
    rd(1'b1, 20'h4_0000, 2'h3, DEV_ID);
  endtask
  task automatic t_dpd;
    wr(1'b1, 20'h0_0000, 16'h0080, 2'h0);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    flag("page mode", 1'b1, pageModeEn);
    flag("deep power-down", 1'b1, deepPowerDown);
    flag("wait enable", 1'b0, waitOe);
    host.wake(8);
    @(negedge mclk);
    flag("deep power-down", 1'b0, deepPowerDown);
    check("refresh config", 16'h0090, refreshConfig);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    t_init();
    t_lanes();
    t_config();
    t_dpd();
    report_and_stop();
  end
  initial begin
    repeat (6000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end
endmodule
